/* File: lhr_pkg.sv */
// Shared constants for the line hook and ring control link.
// Assumes a 100 MHz system clock on both ends.
package lhr_pkg;

  // Timing: system clock period and the least squelch pulse length.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SQUELCH_MIN_US = 1000;
  localparam int unsigned SQUELCH_CYCLES_DEF =
    (SQUELCH_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFFHOOK_CYCLES_DEF = 256;

  // Device register indices on the link.
  localparam logic [4:0] DEV_REG_HOOK = 5'h05;
  localparam logic [4:0] DEV_REG_MODE = 5'h10;
  localparam logic [4:0] DEV_REG_RING = 5'h12;
  localparam logic [4:0] DEV_REG_SENSE = 5'h13;

  // Field positions in the device registers.
  localparam int unsigned HOOK_MON_BIT = 0;
  localparam int unsigned HOOK_OH_BIT = 1;
  localparam int unsigned MODE_BIT = 0;
  localparam int unsigned MODE_RZ_BIT = 1;
  localparam int unsigned MODE_CIDSQ_BIT = 2;
  localparam int unsigned RING_SQ_BIT = 0;
  localparam int unsigned RING_FW_BIT = 1;
  localparam int unsigned SENSE_LSB = 3;

  // Device register reset values.
  localparam logic [1:0] HOOK_RST = 2'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] RING_RST = 2'h0;

  // Sense field extremes shown during a ring event.
  localparam logic [4:0] SENSE_ALL_ONES = 5'h1F;
  localparam logic [4:0] SENSE_ALL_ZEROS = 5'h00;

  // Hook state codes {mode, hook_control, onhook_monitor_enable}.
  localparam logic [2:0] HS_OFFHOOK = 3'h2;
  localparam logic [2:0] HS_FAST_SETTLE = 3'h3;
  localparam logic [2:0] HS_ONHOOK = 3'h4;
  localparam logic [2:0] HS_ONHOOK_MON = 3'h5;
  localparam logic [2:0] HS_FORCE = 3'h6;
  localparam logic [2:0] HS_FORCE_MON = 3'h7;

  // Controller register byte offsets on AXI4-Lite.
  localparam logic [3:0] CSR_CFG = 4'h0;
  localparam logic [3:0] CSR_SQUELCH = 4'h4;
  localparam logic [3:0] CSR_SENSE_REQ = 4'h8;
  localparam logic [3:0] CSR_STATUS = 4'hC;

  // Configuration register fields.
  localparam int unsigned CFG_HS_LSB = 0;
  localparam int unsigned CFG_RZ_BIT = 3;
  localparam int unsigned CFG_CIDSQ_BIT = 4;
  localparam int unsigned CFG_FW_BIT = 5;
  localparam logic [5:0] CFG_RST = 6'h00;

  // Status register fields.
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_SQ_BIT = 1;
  localparam int unsigned ST_FAST_BIT = 2;
  localparam int unsigned ST_VALID_BIT = 4;
  localparam int unsigned ST_SENSE_LSB = 8;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

/* File: lhr_link_if.sv */
// Register link between the controller and the line-side device.
// Assumes both ends share clk_i; the bench joins them with this.
`timescale 1ns/1ps
interface lhr_link_if;
  logic wr_en;
  logic rd_en;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport dev (
    input wr_en,
    input rd_en,
    input addr,
    input wdata,
    output rdata
  );

  modport ctl (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input rdata
  );
endinterface

/* File: lhr_device.sv */
// Line-side device: hook, sense, ring rectify and squelch registers.
// Assumes line_voltage_i and loop_current_i come from a converter on
// clk_i; the ring comparators and line data arrive from pins.
`timescale 1ns/1ps
module lhr_device
  import lhr_pkg::*;
#(
  parameter int unsigned OFFHOOK_CYCLES = OFFHOOK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  lhr_link_if.dev link,
  input wire logic ring_pos_i,
  input wire logic ring_neg_i,
  input wire logic line_data_i,
  input wire logic [4:0] line_voltage_i,
  input wire logic [4:0] loop_current_i,
  output logic line_seized_o,
  output logic ring_detect_o,
  output logic serial_data_o,
  output logic squelch_active_o,
  output logic low_current_monitor_o,
  output logic fast_settle_o,
  output logic offhook_settled_o
);

  initial begin
    if (OFFHOOK_CYCLES < 1 || OFFHOOK_CYCLES > 65535) begin
      $error("OFFHOOK_CYCLES out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [1:0] hook_q, hook_d;
  logic [2:0] mode_q, mode_d;
  logic [1:0] ring_q, ring_d;
  logic [7:0] rdata_q, rdata_d;
  logic [4:0] sense_q, sense_d;
  logic [15:0] cnt_q, cnt_d;
  logic rdet_q, rdet_d;
  logic sdo_q, sdo_d;
  logic [2:0] hs;
  logic seized;
  logic forced;
  logic rect;

  assign hs = {mode_q[MODE_BIT], hook_q[HOOK_OH_BIT], hook_q[HOOK_MON_BIT]};
  assign seized = (hs == HS_OFFHOOK) || (hs == HS_FAST_SETTLE);
  assign forced = (hs == HS_FORCE) || (hs == HS_FORCE_MON);
  // Full wave passes either half-cycle, half wave only the positive one.
  assign rect = ring_q[RING_FW_BIT] ? (sync2_q[0] | sync2_q[1])
                                    : sync2_q[0];

  // Next register, sense and pin values.
  always_comb begin
    hook_d = hook_q;
    mode_d = mode_q;
    ring_d = ring_q;
    rdata_d = rdata_q;
    if (link.wr_en) begin
      unique case (link.addr)
        DEV_REG_HOOK: hook_d = link.wdata[1:0];
        DEV_REG_MODE: mode_d = link.wdata[2:0];
        DEV_REG_RING: ring_d = link.wdata[1:0];
        default: ;
      endcase
    end
    if (link.rd_en) begin
      unique case (link.addr)
        DEV_REG_HOOK: rdata_d = {6'h00, hook_q};
        DEV_REG_MODE: rdata_d = {5'h00, mode_q};
        DEV_REG_RING: rdata_d = {6'h00, ring_q};
        DEV_REG_SENSE: rdata_d = {sense_q, 3'h0};
        default: rdata_d = 8'h00;
      endcase
    end
    // Force on-hook freezes the counter so caller ID needs no restart.
    if (seized) begin
      cnt_d = (cnt_q == 16'(OFFHOOK_CYCLES)) ? cnt_q : cnt_q + 16'h0001;
    end else if (forced) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = 16'h0000;
    end
    if (mode_q[MODE_RZ_BIT] && rdet_q) begin
      sense_d = (line_voltage_i != 5'h00) ? SENSE_ALL_ONES
                                          : SENSE_ALL_ZEROS;
    end else if (seized) begin
      sense_d = loop_current_i;
    end else if (hook_q[HOOK_MON_BIT]) begin
      sense_d = 5'h00;
    end else begin
      sense_d = line_voltage_i;
    end
    rdet_d = rect;
    if (hs == HS_ONHOOK) begin
      sdo_d = rect;
    end else if (hs == HS_FORCE) begin
      sdo_d = 1'b0;
    end else begin
      sdo_d = sync2_q[2];
    end
  end

  // Register stage; the first synchroniser stage feeds only the second.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      hook_q <= HOOK_RST;
      mode_q <= MODE_RST;
      ring_q <= RING_RST;
      rdata_q <= 8'h00;
      sense_q <= 5'h00;
      cnt_q <= 16'h0000;
      rdet_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      sync1_q <= {line_data_i, ring_neg_i, ring_pos_i};
      sync2_q <= sync1_q;
      hook_q <= hook_d;
      mode_q <= mode_d;
      ring_q <= ring_d;
      rdata_q <= rdata_d;
      sense_q <= sense_d;
      cnt_q <= cnt_d;
      rdet_q <= rdet_d;
      sdo_q <= sdo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Squelch follows the bit directly to recover the ring pin offset.
  assign squelch_active_o = ring_q[RING_SQ_BIT];
  assign link.rdata = rdata_q;
  assign line_seized_o = seized;
  assign ring_detect_o = rdet_q;
  assign serial_data_o = sdo_q;
  assign low_current_monitor_o = mode_q[MODE_BIT] & hook_q[HOOK_MON_BIT];
  assign fast_settle_o = (hs == HS_FAST_SETTLE);
  assign offhook_settled_o = (cnt_q == 16'(OFFHOOK_CYCLES));

endmodule // lhr_device

/* File: lhr_host.sv */
// Controller end: AXI4-Lite registers that drive safe device sequences.
// Function
// - ring event shows sense all ones or zeros
// - force on-hook keeps the off-hook counter
// - order writes to avoid unwanted hook states
// - no data sent during fast settle
// - clear monitor before hook, set monitor last
// - full or half wave ring rectification
// - squelch pulse lasts at least one millisecond
// - squelch bit restores ring pin offset
// - no ring squelch while caller ID squelch
// Assumes the device shares clk_i and answers reads one edge later.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module lhr_host
  import lhr_pkg::*;
#(
  parameter int unsigned SQUELCH_CYCLES = SQUELCH_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [3:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  lhr_link_if.ctl link,
  output logic tx_inhibit_o,
  output logic busy_o
);

  initial begin
    if (SQUELCH_CYCLES < 1 || SQUELCH_CYCLES > 24'hFFFFFF) begin
      $error("SQUELCH_CYCLES out of range");
    end
  end

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_CLR_MON = 11'h002,
    ST_MODE = 11'h004,
    ST_HOOK = 11'h008,
    ST_MON = 11'h010,
    ST_RING = 11'h020,
    ST_SQ_SET = 11'h040,
    ST_SQ_WAIT = 11'h080,
    ST_SQ_CLR = 11'h100,
    ST_RD_REQ = 11'h200,
    ST_RD_WAIT = 11'h400
  } lhr_state_t;

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave state.
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [5:0] cfg_q, cfg_d;
  logic go_cfg, go_sq, go_rd;
  // Sequencer state.
  lhr_state_t st_q, st_d;
  logic [23:0] cnt_q, cnt_d;
  logic oh_q, oh_d;
  logic sq_on_q, sq_on_d;
  logic fast_q, fast_d;
  logic [4:0] sense_q, sense_d;
  logic valid_q, valid_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic [4:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d;
  logic busy;
  logic [31:0] status;

  assign busy = (st_q != ST_IDLE);
  assign status = {19'h00000, sense_q, 3'h0, valid_q, 1'b0, fast_q,
                   sq_on_q, busy};

  // Bus decode; a command that arrives while busy is refused.
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    go_cfg = 1'b0;
    go_sq = 1'b0;
    go_rd = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_i[7:0];
      wstrb0_d = s_axi_wstrb_i[0];
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case ({awaddr_q[3:2], 2'b00})
        CSR_CFG: begin
          if (busy) begin
            bresp_d = RESP_SLVERR;
          end else if (wstrb0_q) begin
            cfg_d = wdata_q[5:0];
            go_cfg = 1'b1;
          end
        end
        CSR_SQUELCH: begin
          // Ring squelch would upset caller ID reception under its squelch.
          if (busy || cfg_q[CFG_CIDSQ_BIT]) begin
            bresp_d = RESP_SLVERR;
          end else if (wstrb0_q && wdata_q[0]) begin
            go_sq = 1'b1;
          end
        end
        CSR_SENSE_REQ: begin
          if (busy) begin
            bresp_d = RESP_SLVERR;
          end else if (wstrb0_q && wdata_q[0]) begin
            go_rd = 1'b1;
          end
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case ({s_axi_araddr_i[3:2], 2'b00})
        CSR_CFG: rdata_d = {26'h0000000, cfg_q};
        CSR_SQUELCH: rdata_d = {31'h00000000, sq_on_q};
        CSR_SENSE_REQ: rdata_d = 32'h00000000;
        CSR_STATUS: rdata_d = status;
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
  end

  // Bus registers.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
      cfg_q <= CFG_RST;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Device sequencer; one link write per state keeps each access apart.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    oh_d = oh_q;
    sq_on_d = sq_on_q;
    fast_d = fast_q;
    sense_d = sense_q;
    valid_d = valid_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    addr_d = addr_q;
    wd_d = wd_q;
    unique case (st_q)
      ST_IDLE: begin
        if (go_cfg) begin
          st_d = ST_CLR_MON;
        end else if (go_sq) begin
          st_d = ST_SQ_SET;
        end else if (go_rd) begin
          st_d = ST_RD_REQ;
        end
      end
      ST_CLR_MON: begin
        // Monitor goes off first, before mode or hook change.
        wr_d = 1'b1;
        addr_d = DEV_REG_HOOK;
        wd_d = {6'h00, oh_q, 1'b0};
        st_d = ST_MODE;
      end
      ST_MODE: begin
        wr_d = 1'b1;
        addr_d = DEV_REG_MODE;
        wd_d = {5'h00, cfg_q[CFG_CIDSQ_BIT], cfg_q[CFG_RZ_BIT],
                cfg_q[CFG_HS_LSB + 2]};
        fast_d = 1'b0;
        st_d = ST_HOOK;
      end
      ST_HOOK: begin
        wr_d = 1'b1;
        addr_d = DEV_REG_HOOK;
        wd_d = {6'h00, cfg_q[CFG_HS_LSB + 1], 1'b0};
        oh_d = cfg_q[CFG_HS_LSB + 1];
        st_d = cfg_q[CFG_HS_LSB] ? ST_MON : ST_RING;
      end
      ST_MON: begin
        // Monitor is set last, in an access of its own.
        wr_d = 1'b1;
        addr_d = DEV_REG_HOOK;
        wd_d = {6'h00, oh_q, 1'b1};
        fast_d = (cfg_q[CFG_HS_LSB +: 3] == HS_FAST_SETTLE);
        st_d = ST_RING;
      end
      ST_RING: begin
        wr_d = 1'b1;
        addr_d = DEV_REG_RING;
        wd_d = {6'h00, cfg_q[CFG_FW_BIT], sq_on_q};
        st_d = ST_IDLE;
      end
      ST_SQ_SET: begin
        wr_d = 1'b1;
        addr_d = DEV_REG_RING;
        wd_d = {6'h00, cfg_q[CFG_FW_BIT], 1'b1};
        sq_on_d = 1'b1;
        cnt_d = 24'h000000;
        st_d = ST_SQ_WAIT;
      end
      ST_SQ_WAIT: begin
        // Holds the squelch for the full least time before clearing.
        if (cnt_q == 24'(SQUELCH_CYCLES - 1)) begin
          st_d = ST_SQ_CLR;
        end else begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
      ST_SQ_CLR: begin
        wr_d = 1'b1;
        addr_d = DEV_REG_RING;
        wd_d = {6'h00, cfg_q[CFG_FW_BIT], 1'b0};
        sq_on_d = 1'b0;
        st_d = ST_IDLE;
      end
      ST_RD_REQ: begin
        rd_d = 1'b1;
        addr_d = DEV_REG_SENSE;
        cnt_d = 24'h000000;
        st_d = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        // The device answers one edge after it sees the read strobe.
        if (cnt_q == 24'h000001) begin
          sense_d = link.rdata[SENSE_LSB +: 5];
          valid_d = 1'b1;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 24'h000001;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequencer registers; link outputs come straight from flip-flops.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 24'h000000;
      oh_q <= 1'b0;
      sq_on_q <= 1'b0;
      fast_q <= 1'b0;
      sense_q <= 5'h00;
      valid_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 5'h00;
      wd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      oh_q <= oh_d;
      sq_on_q <= sq_on_d;
      fast_q <= fast_d;
      sense_q <= sense_d;
      valid_q <= valid_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign link.wr_en = wr_q;
  assign link.rd_en = rd_q;
  assign link.addr = addr_q;
  assign link.wdata = wd_q;
  // The user's transmitter must stay quiet while the line settles.
  assign tx_inhibit_o = fast_q;
  assign busy_o = busy;

endmodule // lhr_host

/* File: lhr_checker.sv */
// Checker for the hook and ring register link between the two ends.
// Assumes it watches the link interface and device pins on one clk_i.
`timescale 1ns/1ps
module lhr_checker
  import lhr_pkg::*;
#(
  parameter int unsigned SQUELCH_CYCLES = SQUELCH_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic squelch_active_o,
  input wire logic fast_settle_o,
  input wire logic tx_inhibit_o,
  input wire logic line_seized_o,
  input wire logic low_current_monitor_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [2:0] hs_q;
  logic [2:0] hs_d;
  logic cid_q;
  logic cid_d;
  int unsigned cnt_q;
  int unsigned cnt_d;

  //////////////////////////////////////////////////////////////////////////
  // Shadow of the device hook state, so the checks see what was written.
  always_comb begin
    hs_d = hs_q;
    cid_d = cid_q;
    if (wr_en && addr == DEV_REG_HOOK) begin
      hs_d[1:0] = {wdata[HOOK_OH_BIT], wdata[HOOK_MON_BIT]};
    end
    if (wr_en && addr == DEV_REG_MODE) begin
      hs_d[2] = wdata[MODE_BIT];
      cid_d = wdata[MODE_CIDSQ_BIT];
    end
    cnt_d = squelch_active_o ? cnt_q + 1 : 0;
  end

  // Registers of the shadow and of the squelch length counter.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hs_q <= 3'h0;
      cid_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      hs_q <= hs_d;
      cid_q <= cid_d;
      cnt_q <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Relations between written state, link order and device outputs.
  AST_SEIZED: assert property (line_seized_o == (hs_q[2:1] == 2'b01))
    else $error("line seizure does not match hook state");
  AST_LOW_MON: assert property (
    low_current_monitor_o == (hs_q[2] && hs_q[0]))
    else $error("low current monitor does not match hook state");
  AST_MODE_ORDER: assert property (wr_en && addr == DEV_REG_MODE |->
    $past(wr_en) && $past(addr) == DEV_REG_HOOK
    && !$past(wdata[HOOK_MON_BIT]))
    else $error("mode written without a preceding safe hook write");
  AST_OH_MON_CLEAR: assert property (wr_en && addr == DEV_REG_HOOK
    && wdata[HOOK_OH_BIT] != hs_q[1] |-> !wdata[HOOK_MON_BIT])
    else $error("hook bit changed with monitor bit set");
  AST_MON_LAST: assert property (wr_en && addr == DEV_REG_HOOK
    && wdata[HOOK_MON_BIT] |-> $past(wr_en)
    && $past(addr) == DEV_REG_HOOK && !$past(wdata[HOOK_MON_BIT])
    && $past(wdata[HOOK_OH_BIT]) == wdata[HOOK_OH_BIT])
    else $error("monitor bit set without a separate hook write first");
  AST_FAST_INHIBIT: assert property (
    fast_settle_o |-> tx_inhibit_o)
    else $error("transmit not inhibited in fast settle");
  AST_SQ_FOLLOW: assert property (wr_en && addr == DEV_REG_RING |=>
    squelch_active_o == $past(wdata[RING_SQ_BIT]))
    else $error("squelch output does not follow its bit");
  AST_SQ_LEN: assert property (
    $fell(squelch_active_o) |-> cnt_q >= SQUELCH_CYCLES)
    else $error("squelch pulse too short");
  AST_SQ_NOT_CID: assert property (wr_en && addr == DEV_REG_RING
    && wdata[RING_SQ_BIT] |-> !cid_q)
    else $error("ring squelch used with caller id squelch on");
endmodule // lhr_checker

/* File: testbench.sv */
// Testbench joining controller and device through the link interface.
// Assumes shortened squelch and off-hook counts to keep the run brief.
`timescale 1ns/1ps
module testbench;
  import lhr_pkg::*;
  localparam int unsigned SQ = 8;
  localparam int unsigned OHC = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic awr, wr, bv, arr, rv, txi, bsy, seized, rdet, serial_data_out, sqa, lcm, fst;
  logic ohs;
  logic [1:0] br, rr, resp;
  logic [31:0] rd, val;
  logic rp = 1'b0, rn = 1'b0, ld = 1'b1;
  logic [4:0] lv = 5'h00;
  logic [2:0] hs;
  logic [2:0] modes [6] = '{HS_OFFHOOK, HS_FAST_SETTLE, HS_ONHOOK,
    HS_ONHOOK_MON, HS_FORCE, HS_FORCE_MON};
  int fails = 0, checked = 0, cyc = 0;
  lhr_link_if link();

  lhr_host #(.SQUELCH_CYCLES(SQ)) i_lhr_host (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .link(link), .tx_inhibit_o(txi), .busy_o(bsy));
  lhr_device #(.OFFHOOK_CYCLES(OHC)) i_lhr_device (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .link(link), .ring_pos_i(rp), .ring_neg_i(rn),
    .line_data_i(ld), .line_voltage_i(lv), .loop_current_i(5'h07),
    .line_seized_o(seized), .ring_detect_o(rdet), .serial_data_o(serial_data_out),
    .squelch_active_o(sqa), .low_current_monitor_o(lcm),
    .fast_settle_o(fst), .offhook_settled_o(ohs));
  lhr_checker #(.SQUELCH_CYCLES(SQ)) i_lhr_checker (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .wr_en(link.wr_en), .addr(link.addr),
    .wdata(link.wdata), .squelch_active_o(sqa), .fast_settle_o(fst),
    .tx_inhibit_o(txi), .line_seized_o(seized),
    .low_current_monitor_o(lcm));

  //////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a lost handshake cannot hang the run.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Ready is looked at mid-cycle, where it is settled for the next edge.
  task axi_wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic at, wt, ta, tw, got;
    @(posedge clk_i);
    at = 1'b0;
    wt = 1'b0;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bre <= 1'b1;
    while (!(at && wt)) begin
      @(negedge clk_i);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk_i);
      if (ta) begin
        at = 1'b1;
        awv <= 1'b0;
      end
      if (tw) begin
        wt = 1'b1;
        wv <= 1'b0;
      end
    end
    got = 1'b0;
    while (!got) begin
      @(negedge clk_i);
      got = bv;
      r = br;
      @(posedge clk_i);
    end
    bre <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic got;
    @(posedge clk_i);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_i);
      got = arv && arr;
      @(posedge clk_i);
    end
    arv <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_i);
      got = rv;
      d = rd;
      if (got) chk({30'h0, rr}, {30'h0, RESP_OKAY});
      @(posedge clk_i);
    end
    rre <= 1'b0;
  endtask

  task settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task wait_idle;
    int i;
    settle(2);
    i = 0;
    while (bsy !== 1'b0 && i < 100) begin
      @(negedge clk_i);
      i++;
    end
    // The last link write lands in the device one edge after idle.
    settle(1);
  endtask

  // Configuration is {fw, cid, rz, hook state}.
  task cfg(input logic [5:0] v);
    axi_wr(CSR_CFG, {26'h0, v}, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    wait_idle();
  endtask

  task sense(input logic [4:0] exp);
    axi_wr(CSR_SENSE_REQ, 32'h1, resp);
    wait_idle();
    axi_rd(CSR_STATUS, val);
    chk({27'h0, val[ST_SENSE_LSB +: 5]}, {27'h0, exp});
    chkb(val[ST_VALID_BIT], 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    axi_rd(CSR_CFG, val);
    chk(val, {26'h0, CFG_RST});
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      hs = modes[k];
      cfg({3'h0, hs});
      chkb(seized, hs[2:1] == 2'b01);
      chkb(fst, hs == HS_FAST_SETTLE);
      chkb(txi, hs == HS_FAST_SETTLE);
      chkb(lcm, hs[2] && hs[0]);
      chkb(serial_data_out, hs != HS_ONHOOK && hs != HS_FORCE);
      axi_rd(CSR_CFG, val);
      chk(val, {29'h0, hs});
    end
    $display("test hook modes done");
    cfg({3'h0, HS_OFFHOOK});
    settle(OHC + 4);
    chkb(ohs, 1'b1);
    cfg({3'h0, HS_FORCE});
    chkb(ohs, 1'b1);
    chkb(seized, 1'b0);
    $display("test force on-hook done");
    @(posedge clk_i);
    rn <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      cfg({f[0], 2'b00, HS_ONHOOK});
      settle(6);
      chkb(rdet, f[0]);
      chkb(serial_data_out, f[0]);
    end
    $display("test rectify done");
    @(posedge clk_i);
    lv <= 5'h0A;
    cfg({3'b101, HS_ONHOOK});
    sense(SENSE_ALL_ONES);
    @(posedge clk_i);
    lv <= 5'h00;
    sense(SENSE_ALL_ZEROS);
    @(posedge clk_i);
    rn <= 1'b0;
    lv <= 5'h0A;
    cfg({3'b000, HS_ONHOOK});
    settle(6);
    sense(5'h0A);
    $display("test ring sense done");
    axi_wr(CSR_SQUELCH, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_wr(CSR_CFG, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    @(negedge clk_i);
    chkb(sqa, 1'b1);
    axi_rd(CSR_STATUS, val);
    chkb(val[ST_SQ_BIT], 1'b1);
    chkb(val[ST_BUSY_BIT], 1'b1);
    wait_idle();
    chkb(sqa, 1'b0);
    cfg({3'b010, HS_ONHOOK});
    axi_wr(CSR_SQUELCH, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    settle(4);
    chkb(sqa, 1'b0);
    $display("test squelch done");
    give_verdict();
  end
endmodule // testbench
